// ---- src/sxa_alu.sv ----
// Datapath for subtract, exclusive-OR and nibble swap operations with flag update.
// Notes on behaviour
// [RL1] Subtract computes file minus work; carry and half-carry set when no borrow.
// [RL2] Destination bit 0 writes work register, 1 writes back to file address 0..127.
// [RL3] Literal exclusive-OR writes work register and updates only the zero flag.
// [RL4] Swap exchanges file nibbles and leaves every status flag unchanged.
// [RL5] File exclusive-OR goes to selected destination and updates only zero flag.
// [RL6] Zero flag, when updated, is set exactly when the 8-bit result is zero.
`timescale 1ns/100ps
module sxa_alu
  import sxa_pkg::*;
(
  // Clock and reset.
  input  wire logic              clk_sys,
  input  wire logic              rst_b,
  // Operation request.
  input  wire logic              op_valid,
  input  wire sxa_op_type        op_code,
  input  wire logic              dest_sel,
  input  wire logic [ADDR_W-1:0] file_addr,
  input  wire logic [DATA_W-1:0] literal,
  // File register read data for the addressed register.
  input  wire logic [DATA_W-1:0] file_rdata,
  // File register write port.
  output logic                   file_we,
  output logic [ADDR_W-1:0]      file_waddr,
  output logic [DATA_W-1:0]      file_wdata,
  // Working register and status flags.
  output logic [DATA_W-1:0]      work_reg,
  output logic                   carry_flag,
  output logic                   half_carry_flag,
  output logic                   zero_flag
);

  typedef struct packed {
    logic [DATA_W-1:0] work;
    logic              carry;
    logic              half_carry;
    logic              zero;
    logic              we;
    logic [ADDR_W-1:0] waddr;
    logic [DATA_W-1:0] wdata;
  } sxa_state_type;

  sxa_state_type st_q;
  sxa_state_type st_d;

  logic [DATA_W:0]   diff;
  logic [NIB_HI:0]   diff_lo;
  logic [DATA_W-1:0] result;
  logic              to_file;

  always_comb begin
    st_d    = st_q;
    st_d.we = 1'b0;
    diff    = {1'b0, file_rdata} - {1'b0, work_reg};  // RL1
    diff_lo = {1'b0, file_rdata[NIB_HI-1:NIB_LO]} - {1'b0, work_reg[NIB_HI-1:NIB_LO]};
    result  = '0;
    to_file = 1'b0;
    if (op_valid) begin
      case (op_code)
        SXA_OP_SUBTRACT_WORK_FROM_FILE: begin
          result          = diff[DATA_W-1:0];  // RL1
          st_d.carry      = ~diff[DATA_W];  // RL1
          st_d.half_carry = ~diff_lo[NIB_HI];  // RL1
          st_d.zero       = (result == '0);  // RL6
          to_file         = (dest_sel == DEST_FILE);  // RL2
        end
        SXA_OP_XOR_LITERAL_INTO_WORK: begin
          result    = work_reg ^ literal;  // RL3
          st_d.zero = (result == '0);  // RL6
          to_file   = 1'b0;  // RL3
        end
        SXA_OP_SWAP_FILE_NIBBLES: begin
          result  = {file_rdata[NIB_HI-1:NIB_LO], file_rdata[DATA_W-1:NIB_HI]};  // RL4
          to_file = (dest_sel == DEST_FILE);  // RL2
        end
        SXA_OP_XOR_WORK_WITH_FILE: begin
          result    = work_reg ^ file_rdata;  // RL5
          st_d.zero = (result == '0);  // RL6
          to_file   = (dest_sel == DEST_FILE);  // RL5
        end
        default: begin
          result = work_reg;
        end
      endcase
      if (to_file) begin
        st_d.we    = 1'b1;  // RL2
        st_d.waddr = file_addr;
        st_d.wdata = result;
      end else begin
        st_d.work = result;  // RL2
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rst_b) begin
    if (!rst_b) begin
      st_q <= '{work: W_RESET, carry: 1'b0, half_carry: 1'b0, zero: 1'b0,
                we: 1'b0, waddr: '0, wdata: '0};
    end else begin
      st_q <= st_d;
    end
  end

  assign work_reg        = st_q.work;
  assign carry_flag      = st_q.carry;
  assign half_carry_flag = st_q.half_carry;
  assign zero_flag       = st_q.zero;
  assign file_we         = st_q.we;
  assign file_waddr      = st_q.waddr;
  assign file_wdata      = st_q.wdata;

  AST_SUB_VALUE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL1
    op_valid && op_code == SXA_OP_SUBTRACT_WORK_FROM_FILE && dest_sel == DEST_FILE
    |=> file_wdata == $past(file_rdata) - $past(work_reg))
    else $error("Subtract result wrong.");

  AST_SUB_CARRY: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL1
    op_valid && op_code == SXA_OP_SUBTRACT_WORK_FROM_FILE
    |=> carry_flag == ($past(work_reg) <= $past(file_rdata))
        && half_carry_flag == ($past(work_reg[3:0]) <= $past(file_rdata[3:0])))
    else $error("Subtract carry or half-carry wrong.");

  AST_DEST_FILE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL2
    op_valid && op_code != SXA_OP_XOR_LITERAL_INTO_WORK && dest_sel == DEST_FILE
    |=> file_we && file_waddr == $past(file_addr) && $stable(work_reg))
    else $error("File destination not written.");

  AST_DEST_WORK: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL2
    op_valid && dest_sel == DEST_WORK |=> !file_we)
    else $error("File written with work destination.");

  AST_XORL: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL3
    op_valid && op_code == SXA_OP_XOR_LITERAL_INTO_WORK
    |=> work_reg == ($past(work_reg) ^ $past(literal)) && !file_we
        && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("Literal exclusive-OR wrong.");

  AST_SWAP: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL4
    op_valid && op_code == SXA_OP_SWAP_FILE_NIBBLES && dest_sel == DEST_WORK
    |=> work_reg == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
        && $stable(zero_flag) && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("Nibble swap wrong or flags changed.");

  AST_XORF: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL5
    op_valid && op_code == SXA_OP_XOR_WORK_WITH_FILE && dest_sel == DEST_FILE
    |=> file_wdata == ($past(work_reg) ^ $past(file_rdata))
        && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("File exclusive-OR wrong.");

  AST_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL6
    op_valid && op_code != SXA_OP_SWAP_FILE_NIBBLES && dest_sel == DEST_WORK
    |=> zero_flag == (work_reg == 8'h00))
    else $error("Zero flag wrong.");

  AST_IDLE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL2
    !op_valid |=> !file_we && $stable(work_reg) && $stable(zero_flag))
    else $error("State changed with no operation.");

  AST_SUB_WORK: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL1
    op_valid && op_code == SXA_OP_SUBTRACT_WORK_FROM_FILE && dest_sel == DEST_WORK
    |=> work_reg == $past(file_rdata) - $past(work_reg) && !file_we)
    else $error("Subtract result to work register wrong.");

  AST_SUB_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL6
    op_valid && op_code == SXA_OP_SUBTRACT_WORK_FROM_FILE
    |=> zero_flag == ($past(file_rdata) == $past(work_reg)))
    else $error("Subtract zero flag wrong.");

  AST_XORL_NO_FILE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL3
    op_valid && op_code == SXA_OP_XOR_LITERAL_INTO_WORK && dest_sel == DEST_FILE
    |=> !file_we && $stable(file_waddr) && $stable(file_wdata))
    else $error("Literal exclusive-OR touched the file write port.");

  AST_XORL_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL6
    op_valid && op_code == SXA_OP_XOR_LITERAL_INTO_WORK
    |=> zero_flag == ($past(work_reg) == $past(literal)))
    else $error("Literal exclusive-OR zero flag wrong.");

  AST_SWAP_FILE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL4
    op_valid && op_code == SXA_OP_SWAP_FILE_NIBBLES && dest_sel == DEST_FILE
    |=> file_we && file_wdata == {$past(file_rdata[3:0]), $past(file_rdata[7:4])}
        && $stable(zero_flag) && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("Nibble swap to file wrong or flags changed.");

  AST_SWAP_WORK_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL4
    op_valid && op_code == SXA_OP_SWAP_FILE_NIBBLES && dest_sel == DEST_WORK
    |=> !file_we && $stable(file_waddr) && $stable(file_wdata))
    else $error("Nibble swap to work register touched the file write port.");

  AST_XORF_WORK: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL5
    op_valid && op_code == SXA_OP_XOR_WORK_WITH_FILE && dest_sel == DEST_WORK
    |=> work_reg == ($past(work_reg) ^ $past(file_rdata)) && !file_we
        && $stable(carry_flag) && $stable(half_carry_flag))
    else $error("File exclusive-OR to work register wrong.");

  AST_XORF_ZERO: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL6
    op_valid && op_code == SXA_OP_XOR_WORK_WITH_FILE
    |=> zero_flag == ($past(work_reg) == $past(file_rdata)))
    else $error("File exclusive-OR zero flag wrong.");

  AST_ZERO_FILE: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL6
    op_valid && dest_sel == DEST_FILE
    && (op_code == SXA_OP_SUBTRACT_WORK_FROM_FILE || op_code == SXA_OP_XOR_WORK_WITH_FILE)
    |=> zero_flag == (file_wdata == 8'h00))
    else $error("Zero flag wrong for a file destination.");

  AST_FLAGS_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL5
    op_valid && op_code != SXA_OP_SUBTRACT_WORK_FROM_FILE
    |=> $stable(carry_flag) && $stable(half_carry_flag))
    else $error("Carry or half-carry changed by a non-subtract operation.");

  AST_WORK_DEST_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL2
    op_valid && dest_sel == DEST_WORK |=> $stable(file_waddr) && $stable(file_wdata))
    else $error("File write port changed with work destination.");

  AST_IDLE_HOLD: assert property (@(posedge clk_sys) disable iff (!rst_b)  // RL2
    !op_valid |=> $stable(carry_flag) && $stable(half_carry_flag)
        && $stable(file_waddr) && $stable(file_wdata))
    else $error("Flags or write port changed with no operation.");

endmodule : sxa_alu

// ---- src/sxa_pkg.sv ----
// Package with operation codes and widths for the subtract, exclusive-OR and swap datapath.
package sxa_pkg;
  localparam int unsigned DATA_W = 8;
  localparam int unsigned ADDR_W = 7;
  localparam logic [6:0] ADDR_MAX = 7'h7f;
  localparam logic [7:0] W_RESET = 8'h00;
  localparam logic       DEST_WORK = 1'h0;
  localparam logic       DEST_FILE = 1'h1;
  localparam int unsigned NIB_LO = 0;
  localparam int unsigned NIB_HI = 4;

  typedef enum logic [1:0] {
    SXA_OP_SUBTRACT_WORK_FROM_FILE,
    SXA_OP_XOR_LITERAL_INTO_WORK,
    SXA_OP_SWAP_FILE_NIBBLES,
    SXA_OP_XOR_WORK_WITH_FILE
  } sxa_op_type;
endpackage : sxa_pkg

// ---- test/sxa_alu_test.sv ----
// Self-checking bench for the subtract, exclusive-OR and swap datapath.
`timescale 1ns/100ps
module sxa_alu_test
  import sxa_pkg::*;
;
  logic        clk_sys = 1'b0, rst_b = 1'b0, op_valid = 1'b0, dest_sel = 1'b0;
  sxa_op_type  op_code = SXA_OP_SUBTRACT_WORK_FROM_FILE;
  logic [6:0]  file_addr = 7'h00, waddr, m_a = 7'h00;
  logic [7:0]  literal = 8'h00, file_rdata = 8'h00, wdata, work, m_d = 8'h00, m_w = 8'h00;
  logic        we, c, dc, z, m_c = 1'b0, m_dc = 1'b0, m_z = 1'b0;
  logic [26:0] notes[$];
  logic [31:0] seed = 32'h0a7c3788;
  int          bad_count = 0, n_compared = 0, i;

  always #25 clk_sys = ~clk_sys;

  sxa_alu i_dut (.clk_sys(clk_sys), .rst_b(rst_b), .op_valid(op_valid), .op_code(op_code),
    .dest_sel(dest_sel), .file_addr(file_addr), .literal(literal), .file_rdata(file_rdata),
    .file_we(we), .file_waddr(waddr), .file_wdata(wdata), .work_reg(work),
    .carry_flag(c), .half_carry_flag(dc), .zero_flag(z));

  function automatic logic [31:0] lfsr(input logic [31:0] s);
    return {s[30:0], 1'b0} ^ (s[31] ? 32'h04c11db7 : 32'h00000000);
  endfunction : lfsr

  task automatic check(input string name, input logic [26:0] seen, input logic [26:0] exp);
    n_compared++;
    if (seen !== exp) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", name, exp, seen);
    end
  endtask : check

  task automatic final_report;
    $display("compared %0d mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask : final_report

  // Drives one cycle at the falling edge and notes the expected outputs.
  task automatic drive(input logic v, input logic [1:0] k, input logic d,
      input logic [6:0] a, input logic [7:0] l, input logic [7:0] f);
    logic [7:0] r;
    logic       mwe;
    @(negedge clk_sys);
    {op_valid, dest_sel, file_addr, literal, file_rdata} = {v, d, a, l, f};
    op_code = sxa_op_type'(k);
    mwe = 1'b0;
    r = m_w;
    if (v) begin
      case (k)
        2'h0: begin
          r = f - m_w;
          {m_c, m_dc} = {m_w <= f, m_w[3:0] <= f[3:0]};
        end
        2'h1: r = m_w ^ l;
        2'h2: r = {f[3:0], f[7:4]};
        default: r = m_w ^ f;
      endcase
      if (k != 2'h2) m_z = (r == 8'h00);
      if (d && k != 2'h1) {mwe, m_a, m_d} = {1'b1, a, r};
      else m_w = r;
    end
    notes.push_back({mwe, m_a, m_d, m_w, m_c, m_dc, m_z});
  endtask : drive

  // Pulses reset for one cycle in mid-run and notes the cleared outputs.
  task automatic pulse_reset;
    @(negedge clk_sys);
    {rst_b, op_valid} = 2'b00;
    {m_a, m_d, m_w, m_c, m_dc, m_z} = 26'h0;
    notes.push_back(27'h0);
    @(negedge clk_sys);
    rst_b = 1'b1;
  endtask : pulse_reset

  // Compares settled outputs with the oldest note after each rising edge.
  always @(posedge clk_sys) begin
    #10;
    if (notes.size() > 0) check("outputs", {we, waddr, wdata, work, c, dc, z}, notes.pop_front());
  end

  initial begin
    repeat (3) @(negedge clk_sys);
    rst_b = 1'b1;
    drive(1'b1, 2'h1, 1'b1, 7'h00, 8'h01, 8'h00);
    drive(1'b1, 2'h0, 1'b1, 7'h05, 8'h00, 8'h10);
    drive(1'b1, 2'h0, 1'b0, ADDR_MAX, 8'h00, 8'h01);
    drive(1'b1, 2'h1, 1'b0, 7'h00, 8'h21, 8'h00);
    drive(1'b1, 2'h0, 1'b1, 7'h00, 8'h00, 8'h13);
    drive(1'b1, 2'h3, 1'b0, 7'h00, 8'h00, 8'h21);
    drive(1'b1, 2'h2, 1'b1, ADDR_MAX, 8'h00, 8'h5a);
    for (i = 0; i < 400; i++) begin
      seed = lfsr(seed);
      drive(seed[31] | seed[30], seed[1:0], seed[2], seed[9:3], seed[17:10], seed[25:18]);
    end
    pulse_reset();
    drive(1'b1, 2'h0, 1'b0, 7'h00, 8'h00, 8'h00);
    drive(1'b1, 2'h3, 1'b1, 7'h11, 8'h00, 8'h00);
    drive(1'b0, 2'h0, 1'b0, 7'h00, 8'h00, 8'h00);
    for (i = 0; i < 20 && notes.size() > 0; i++) @(negedge clk_sys);
    if (notes.size() > 0) bad_count++;
    final_report();
  end
endmodule : sxa_alu_test
